// [logic/idc_ctrl_regs.sv]
/*
 Control registers of a four-channel DMA controller: channel masks,
 per-channel mode, byte pointer flag, temporary byte and master clear.
 Assumes the I/O port, temp byte load and copy enable come from logic
 on the same clock; DMA request pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module idc_ctrl_regs #(
    parameter int CHANNELS = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic memory_copy_enable,
    input wire logic temp_load,
    input wire logic [7:0] temp_data,
    input wire logic [CHANNELS-1:0] dma_request_pin,
    output logic [CHANNELS-1:0] channel_mask,
    output logic [CHANNELS-1:0] service_request,
    output logic [2*CHANNELS-1:0] transfer_mode,
    output logic [CHANNELS-1:0] address_step_direction,
    output logic [CHANNELS-1:0] auto_reload_enable,
    output logic [2*CHANNELS-1:0] transfer_kind,
    output logic [CHANNELS-1:0] kind_in_use,
    output logic byte_pointer_toggle,
    output logic soft_clear_all
);

    // Offset match for a strobe
    function automatic logic hit(input logic strobe, input logic [3:0] addr,
                                 input logic [3:0] off);
        hit = strobe && (addr == off);
    endfunction

    // Decoded strobes and synchroniser stages
    logic master_clear;
    logic mask_wr;
    logic mode_wr;
    logic all_clear_wr;
    logic word_access;
    logic [1:0] sel;
    logic [CHANNELS-1:0] req_meta;
    logic [CHANNELS-1:0] req_sync;

    // Write decode
    assign master_clear = hit(io_wr, io_addr, idc_pkg::OFF_MASTER_CLEAR);
    assign mask_wr = hit(io_wr, io_addr, idc_pkg::OFF_SINGLE_MASK);
    assign mode_wr = hit(io_wr, io_addr, idc_pkg::OFF_MODE);
    assign all_clear_wr = hit(io_wr, io_addr, idc_pkg::OFF_ALL_MASK_CLEAR);
    assign word_access = (io_wr || io_rd) && (io_addr <= idc_pkg::OFF_WORD_LAST);
    assign sel = io_wdata[idc_pkg::SEL_LSB +: 2];

    // Pulse telling the rest of the controller to reset and go idle
    // Registered so downstream logic sees one clean cycle
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            soft_clear_all <= 1'b0;
        else
            soft_clear_all <= master_clear;
    end

    // Request pin synchroniser
    // Only the second stage feeds logic; the first may be metastable
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_meta <= '0;
            req_sync <= '0;
        end
        else
        begin
            req_meta <= dma_request_pin;
            req_sync <= req_meta;
        end
    end

    // Channel masks; all-clear wins over a single set in the same cycle
    // Reset and master clear leave every channel masked
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            channel_mask <= idc_pkg::MASK_RESET;
        else if (master_clear)
            channel_mask <= idc_pkg::MASK_RESET;
        else if (all_clear_wr)
            channel_mask <= '0;
        else if (mask_wr)
            channel_mask[sel] <= io_wdata[idc_pkg::MASK_VALUE_BIT];
    end

    // Requests passed on only for unmasked channels
    // Pin to output takes three edges: two sync stages and this flop
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            service_request <= '0;
        else if (master_clear)
            service_request <= '0;
        else
            service_request <= req_sync & ~channel_mask;
    end

    // Per-channel mode fields
    // Each channel owns one slice of every packed mode field
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_mode
            logic mode_here;
            assign mode_here = mode_wr && (sel == 2'(ch));

            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    transfer_mode[2*ch +: 2] <= idc_pkg::MODE_FIELD_RESET;
                    address_step_direction[ch] <= 1'b0;
                    auto_reload_enable[ch] <= 1'b0;
                    transfer_kind[2*ch +: 2] <= idc_pkg::KIND_RESET;
                end
                else if (master_clear)
                begin
                    transfer_mode[2*ch +: 2] <= idc_pkg::MODE_FIELD_RESET;
                    address_step_direction[ch] <= 1'b0;
                    auto_reload_enable[ch] <= 1'b0;
                    transfer_kind[2*ch +: 2] <= idc_pkg::KIND_RESET;
                end
                else if (mode_here)
                begin
                    transfer_mode[2*ch +: 2] <= io_wdata[idc_pkg::MODE_LSB +: 2];
                    address_step_direction[ch] <= io_wdata[idc_pkg::DIR_BIT];
                    auto_reload_enable[ch] <= io_wdata[idc_pkg::AUTO_BIT];
                    transfer_kind[2*ch +: 2] <= io_wdata[idc_pkg::KIND_LSB +: 2];
                end
            end

            // Kind matters only outside cascade and memory copy
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    kind_in_use[ch] <= 1'b0;
                else
                    kind_in_use[ch] <= !memory_copy_enable &&
                        (transfer_mode[2*ch +: 2] != idc_pkg::IDC_CASCADE);
            end

            // Kind flag follows the stored mode one cycle later
            cascade_kind_a: assert property (@(posedge clock) disable iff (!rst_b)
                transfer_mode[2*ch +: 2] == idc_pkg::IDC_CASCADE
                |=> !kind_in_use[ch])
                else $error("kind in use under cascade");

            kind_used_a: assert property (@(posedge clock) disable iff (!rst_b)
                rst_b && !memory_copy_enable && transfer_mode[2*ch +: 2] != idc_pkg::IDC_CASCADE
                |=> kind_in_use[ch])
                else $error("kind unused outside cascade and copy");
        end
    endgenerate

    // Byte pointer: cleared by its register, toggled by word byte accesses
    // One offset per cycle, so clear and toggle never meet
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            byte_pointer_toggle <= idc_pkg::BPTR_RESET;
        else if (master_clear || hit(io_wr, io_addr, idc_pkg::OFF_BPTR_CLEAR))
            byte_pointer_toggle <= idc_pkg::BPTR_RESET;
        else if (word_access)
            byte_pointer_toggle <= !byte_pointer_toggle;
    end

    // Temporary byte caught from the memory copy path
    // Master clear empties it as a hardware reset would
    logic [7:0] temp_byte;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            temp_byte <= idc_pkg::TEMP_RESET;
        else if (master_clear)
            temp_byte <= idc_pkg::TEMP_RESET;
        else if (temp_load)
            temp_byte <= temp_data;
    end

    // Read data, one cycle after the read strobe; other offsets read zero
    // A read at the shared offset never starts a master clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            io_rdata <= idc_pkg::RDATA_RESET;
        else if (hit(io_rd, io_addr, idc_pkg::OFF_TEMP_READ))
            io_rdata <= temp_byte;
        else
            io_rdata <= idc_pkg::RDATA_RESET;
    end

    // Checks
    single_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        mask_wr && !master_clear && !all_clear_wr
        |=> channel_mask[$past(sel)] == $past(io_wdata[idc_pkg::MASK_VALUE_BIT]))
        else $error("single mask write not applied");

    mode_field_a: assert property (@(posedge clock) disable iff (!rst_b)
        mode_wr && !master_clear
        |=> transfer_mode[2*$past(sel) +: 2] == $past(io_wdata[7:6]))
        else $error("transfer mode not stored");

    step_dir_a: assert property (@(posedge clock) disable iff (!rst_b)
        mode_wr && !master_clear
        |=> address_step_direction[$past(sel)] == $past(io_wdata[5]))
        else $error("step direction not stored");

    auto_reload_a: assert property (@(posedge clock) disable iff (!rst_b)
        mode_wr && !master_clear
        |=> auto_reload_enable[$past(sel)] == $past(io_wdata[4]))
        else $error("auto reload not stored");

    kind_field_a: assert property (@(posedge clock) disable iff (!rst_b)
        mode_wr && !master_clear
        |=> transfer_kind[2*$past(sel) +: 2] == $past(io_wdata[3:2]))
        else $error("transfer kind not stored");

    kind_ignored_a: assert property (@(posedge clock) disable iff (!rst_b)
        memory_copy_enable |=> kind_in_use == '0)
        else $error("kind in use during memory copy");

    other_chan_a: assert property (@(posedge clock) disable iff (!rst_b)
        mode_wr && !master_clear && sel != 2'h0
        |=> $stable(transfer_mode[1:0]) && $stable(transfer_kind[1:0]))
        else $error("mode write touched wrong channel");

    bptr_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        hit(io_wr, io_addr, idc_pkg::OFF_BPTR_CLEAR) ##1 !word_access
        |=> !byte_pointer_toggle)
        else $error("byte pointer not cleared");

    temp_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        hit(io_rd, io_addr, idc_pkg::OFF_TEMP_READ) |=> io_rdata == $past(temp_byte))
        else $error("temporary byte read wrong");

    master_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        master_clear |=> channel_mask == idc_pkg::MASK_RESET && !byte_pointer_toggle
        && soft_clear_all && transfer_mode == '0 && service_request == '0)
        else $error("master clear incomplete");

    all_unmask_a: assert property (@(posedge clock) disable iff (!rst_b)
        all_clear_wr && !master_clear |=> channel_mask == '0)
        else $error("all-mask clear failed");

    bptr_toggle_a: assert property (@(posedge clock) disable iff (!rst_b)
        word_access && !master_clear ##1 word_access && !master_clear
        |=> byte_pointer_toggle == $past(byte_pointer_toggle, 2))
        else $error("byte pointer did not alternate");

    // Request gating, byte pointer step, read data, the clear pulse and single mask isolation
    masked_request_a: assert property (@(posedge clock) disable iff (!rst_b)
        !master_clear
        |=> service_request == ($past(req_sync) & ~$past(channel_mask)))
        else $error("masked channel request passed on");

    bptr_step_a: assert property (@(posedge clock) disable iff (!rst_b)
        word_access && !master_clear
        |=> byte_pointer_toggle != $past(byte_pointer_toggle))
        else $error("byte pointer did not toggle");

    // A strobe must leave no trace the cycle after
    soft_pulse_a: assert property (@(posedge clock) disable iff (!rst_b)
        !master_clear
        |=> !soft_clear_all)
        else $error("master clear pulse too long");

    read_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        io_rd && io_addr != idc_pkg::OFF_TEMP_READ
        |=> io_rdata == idc_pkg::RDATA_RESET)
        else $error("unmapped read returned data");

    other_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        mask_wr && sel != 2'h0
        |=> $stable(channel_mask[0]))
        else $error("mask write touched channel 0");

endmodule // idc_ctrl_regs
`default_nettype wire

// [common/idc_pkg.sv]
/*
 Constants for the DMA channel control registers: I/O offsets, field
 positions, reset values and mode encodings.
 Assumes a 4-bit I/O offset inside the DMA controller's I/O window.
*/
`default_nettype none
package idc_pkg;
    // I/O offsets inside the window
    localparam logic [3:0] OFF_WORD_LAST = 4'h7;
    localparam logic [3:0] OFF_SINGLE_MASK = 4'hA;
    localparam logic [3:0] OFF_MODE = 4'hB;
    localparam logic [3:0] OFF_BPTR_CLEAR = 4'hC;
    localparam logic [3:0] OFF_TEMP_READ = 4'hD;
    localparam logic [3:0] OFF_MASTER_CLEAR = 4'hD;
    localparam logic [3:0] OFF_ALL_MASK_CLEAR = 4'hE;
    // Field positions in written bytes
    localparam int SEL_LSB = 0;
    localparam int MASK_VALUE_BIT = 2;
    localparam int KIND_LSB = 2;
    localparam int AUTO_BIT = 4;
    localparam int DIR_BIT = 5;
    localparam int MODE_LSB = 6;
    // Values after reset or master clear
    localparam logic [3:0] MASK_RESET = 4'hF;
    localparam logic [1:0] MODE_FIELD_RESET = 2'h0;
    localparam logic [1:0] KIND_RESET = 2'h0;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic BPTR_RESET = 1'b0;
    // Channel transfer modes
    typedef enum logic [1:0] {
        IDC_DEMAND,
        IDC_SINGLE,
        IDC_BLOCK,
        IDC_CASCADE
    } idc_xfer_mode_t;
    // Transfer kinds; the last code must never be programmed
    typedef enum logic [1:0] {
        IDC_VERIFY,
        IDC_WRITE,
        IDC_READ,
        IDC_ILLEGAL
    } idc_kind_t;
endpackage
`default_nettype wire

// [tb/idc_periph_model.sv]
/*
 Model of the peripherals beside the DMA control registers: request
 pins and the memory-copy byte source feeding the temporary byte.
 Assumes the bench commands it on the rising edge of clock.
*/
`timescale 1ns/1ps
`default_nettype none
module idc_periph_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] want_service,
    input wire logic copy_go,
    input wire logic [7:0] copy_byte,
    output logic [3:0] dma_request_pin,
    output logic temp_load,
    output var logic [7:0] temp_data
);
    // Request pins are plain levels from each peripheral
    assign dma_request_pin = want_service;
    // One-cycle copy strobe; the byte bus shows junk otherwise
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            temp_load <= 1'b0;
            temp_data <= 8'h00;
        end
        else
        begin
            temp_load <= copy_go;
            temp_data <= copy_go ? copy_byte : ~temp_data;
        end
    end
endmodule // idc_periph_model
`default_nettype wire

// [tb/test_isa_dma_channel_control_regs.sv]
/*
 Self-checking bench for the DMA channel control registers.
 Assumes idc_pkg, the design and the peripheral model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_isa_dma_channel_control_regs;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] io_addr = 4'h0;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic memory_copy_enable = 1'b0;
    logic [3:0] want_service = 4'h0;
    logic copy_go = 1'b0;
    logic [7:0] copy_byte = 8'h00;
    logic [7:0] io_rdata, mode_vec, kind_vec, temp_data;
    logic [3:0] channel_mask, service_request, dir_vec, auto_vec, kind_in_use, dma_request_pin;
    logic temp_load, byte_pointer_toggle, soft_clear_all;
    int failures = 0;
    int check_count = 0;
    // Design and peripheral side
    idc_ctrl_regs #(.CHANNELS(4)) DUT (.clock(clock), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .memory_copy_enable(memory_copy_enable),
        .temp_load(temp_load), .temp_data(temp_data), .dma_request_pin(dma_request_pin),
        .channel_mask(channel_mask), .service_request(service_request), .transfer_mode(mode_vec),
        .address_step_direction(dir_vec), .auto_reload_enable(auto_vec), .transfer_kind(kind_vec),
        .kind_in_use(kind_in_use), .byte_pointer_toggle(byte_pointer_toggle), .soft_clear_all(soft_clear_all));
    idc_periph_model PEER (.clock(clock), .rst_b(rst_b), .want_service(want_service), .copy_go(copy_go),
        .copy_byte(copy_byte), .dma_request_pin(dma_request_pin), .temp_load(temp_load), .temp_data(temp_data));
    // Clock at 50 MHz
    initial
    begin
        forever #10 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One-cycle write strobe, outputs checked after the taking edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        #1;
        chk(io_rdata, exp);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk(8'(channel_mask), 8'h0F);
        wr(4'hE, 8'h5A);
        chk(8'(channel_mask), 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'hA, 8'(4 + i));
            chk(8'(channel_mask), 8'(1 << i));
            wr(4'hA, 8'(248 + i));
            chk(8'(channel_mask), 8'h00);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(4'hB, 8'(i * 64 + (i % 2) * 32 + (i / 2) * 16 + (i % 3) * 4 + (3 - i)));
            chk(8'(mode_vec[2 * (3 - i) +: 2]), 8'(i));
        end
        chk(mode_vec, 8'h1B);
        chk(8'(dir_vec), 8'h05);
        chk(8'(auto_vec), 8'h03);
        chk(kind_vec, 8'h18);
        tick(2);
        chk(8'(kind_in_use), 8'h0E);
        @(posedge clock);
        memory_copy_enable <= 1'b1;
        tick(3);
        chk(8'(kind_in_use), 8'h00);
        @(posedge clock);
        memory_copy_enable <= 1'b0;
        tick(2);
        chk(8'(kind_in_use), 8'h0E);
        wr(4'hC, 8'h00);
        chk(8'(byte_pointer_toggle), 8'h00);
        rd(4'h2, 8'h00);
        chk(8'(byte_pointer_toggle), 8'h01);
        wr(4'h7, 8'h12);
        chk(8'(byte_pointer_toggle), 8'h00);
        wr(4'h0, 8'h34);
        chk(8'(byte_pointer_toggle), 8'h01);
        wr(4'hC, 8'hFF);
        chk(8'(byte_pointer_toggle), 8'h00);
        // Three word accesses on consecutive edges
        @(posedge clock);
        io_addr <= 4'h3;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        #1;
        chk(io_rdata, 8'h00);
        chk(8'(byte_pointer_toggle), 8'h01);
        wr(4'hC, 8'h77);
        chk(8'(byte_pointer_toggle), 8'h00);
        copy_byte <= 8'hA5;
        copy_go <= 1'b1;
        @(posedge clock);
        copy_go <= 1'b0;
        tick(2);
        rd(4'hD, 8'hA5);
        chk(8'(channel_mask), 8'h00);
        rd(4'hB, 8'h00);
        wr(4'hA, 8'h06);
        want_service <= 4'h5;
        tick(4);
        chk(8'(service_request), 8'h01);
        rd(4'h1, 8'h00);
        wr(4'hD, 8'h3C);
        chk(8'(soft_clear_all), 8'h01);
        chk(8'(channel_mask), 8'h0F);
        chk({mode_vec[3:0], dir_vec}, 8'h00);
        chk({auto_vec, 3'h0, byte_pointer_toggle}, 8'h00);
        chk(kind_vec, 8'h00);
        tick(1);
        chk({service_request, 3'h0, soft_clear_all}, 8'h00);
        rd(4'hD, 8'h00);
        report_and_stop;
    end
    // Watchdog against a hang
    initial
    begin
        repeat (3000) @(posedge clock);
        failures++;
        report_and_stop;
    end
endmodule // test_isa_dma_channel_control_regs
`default_nettype wire
